// ==== dv/cpu_irq_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpu_irq_model (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bench commands
	input  wire logic       go_wfi,
	input  wire logic       go_halt,
	input  wire logic [2:0] load,
	// Core side
	input  wire logic       fetch_vector,
	output var  logic       wfi_instr,
	output var  logic       halt_instr,
	output var  logic [2:0] irq
);
	// Request latch clears only when its vector is fetched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 3'h0;
		end else if (load != 3'h0) begin
			irq <= load;
		end else if (fetch_vector) begin
			irq <= 3'h0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wfi_instr <= 1'b0;
			halt_instr <= 1'b0;
		end else begin
			wfi_instr <= go_wfi;
			halt_instr <= go_halt;
		end
	end
endmodule // cpu_irq_model
`default_nettype wire

// ==== dv/power_saving_mode_controller_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module power_saving_mode_controller_bench;
	localparam int SU = 16;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, perr, cpu_clk_en, prio_force, cc_push;
	logic        fetch_vector, watchdog_reset, periph_clk_en, time_base_clk_en;
	logic        osc_enable, wfi_instr, halt_instr, go_wfi = 0, go_halt = 0;
	logic        watchdog_active = 0;
	logic [1:0]  prio_value, isr_priority = 2'h0;
	logic [2:0]  irq, load = 3'h0;
	int          errors = 0, comparisons = 0, pushes = 0, fetches = 0, forces = 0;
	int          p, c, q, t, n, f;
	int unsigned seed = 93;
	int          cq[$] = '{1, 3, 5, 7};

	power_saving_mode_controller #(.STARTUP_CYC(SU)) dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wfi_instr,
		.halt_instr, .watchdog_active, .isr_priority, .cpu_clk_en, .prio_force,
		.prio_value, .cc_push, .fetch_vector, .watchdog_reset, .irq_any(irq[0]),
		.irq_halt_wake(irq[1]), .irq_time_base(irq[2]), .periph_clk_en,
		.time_base_clk_en, .osc_enable);
	cpu_irq_model partner (.pclk, .presetn, .go_wfi, .go_halt, .load, .fetch_vector,
		.wfi_instr, .halt_instr, .irq);

	initial begin
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (cc_push === 1'b1) pushes++;
		if (fetch_vector === 1'b1) fetches++;
		if (prio_force === 1'b1) forces++;
	end
	function int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Reference model of the divider and of the halt decision
	function int div_of(int ctl);
		return (ctl & 1) ? 4 << ((ctl >> 1) & 3) : 2;
	endfunction
	function int hm(int ctl, int wd);
		if ((ctl >> 3) & 1) return 4;
		if (wd && ((ctl >> 4) & 1)) return 32;
		return 8;
	endfunction
	task chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask
	task wrap_up();
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// No local limit: only the bench watchdog may end a stalled transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wm(input logic [31:0] m, input string nm);
		for (int i = 0; i < 40; i++) begin
			apb(0, 12'h004, 0);
			if (rdat === m) break;
		end
		chk(nm, rdat, m);
	endtask
	task cmd(input logic w, h, input logic [2:0] r);
		go_wfi <= w;
		go_halt <= h;
		load <= r;
		@(posedge pclk);
		go_wfi <= 0;
		go_halt <= 0;
		load <= 0;
		@(posedge pclk);
	endtask
	task per(output int pp);
		repeat (2) begin
			pp = 0;
			do begin
				@(posedge pclk);
				pp++;
			end while (cpu_clk_en !== 1'b1 && pp < 99);
		end
	endtask
	task cnt();
		c = 0;
		q = 0;
		t = 0;
		repeat (128) begin
			@(posedge pclk);
			c += cpu_clk_en;
			q += periph_clk_en;
			t += time_base_clk_en;
		end
	endtask

	initial begin
		#100000;
		errors++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		wm(1, "status");
		chk("prio", prio_value, 2);
		per(p);
		chk("run div", p, div_of(0));
		foreach (cq[i]) begin
			apb(1, 12'h000, cq[i]);
			per(p);
			per(p); // Second period only: change waits for a wrap
			chk("slow div", p, div_of(cq[i]));
			apb(0, 12'h000, 0);
			chk("ctrl", rdat, cq[i]);
		end
		isr_priority <= 2'(xs());
		cmd(1, 0, 0);
		wm(2, "wait");
		cnt();
		chk("cpu in wait", c, 0);
		chk("slow wait", q, 128 / div_of(7));
		chk("wait prio", prio_value, 2);
		cmd(0, 0, 3'h1);
		wm(1, "wake");
		chk("prio load", prio_value, isr_priority);
		chk("push", pushes, 1);
		chk("force", forces, 2);
		apb(1, 12'h008, 32'h5);
		chk("err", perr, 1);
		apb(0, 12'h000, 0);
		chk("ctrl kept", rdat, 7);
		apb(1, 12'h000, 0);
		cmd(0, 1, 0);
		wm(hm(0, 0), "halt");
		chk("osc off", osc_enable, 0);
		cnt();
		chk("halt clk", c + q + t, 0);
		cmd(0, 0, 3'h5);
		repeat (8) @(posedge pclk);
		wm(8, "tb halt");
		f = fetches;
		cmd(0, 0, 3'h3);
		for (n = 0; fetches == f && n < 99; n++) @(posedge pclk);
		chk("startup", n >= SU && n <= SU + 10, 1);
		watchdog_active <= 1;
		apb(1, 12'h000, 32'h18);
		cmd(0, 1, 0);
		wm(hm(24, 1), "ahalt");
		chk("no wd rst", watchdog_reset, 0);
		cnt();
		chk("ahalt clk", c + q, 0);
		chk("tb clk", t > 0, 1);
		cmd(0, 0, 3'h5);
		wm(1, "tb wake");
		f = fetches;
		cmd(0, 1, 3'h3);
		wm(1, "pending");
		chk("pending fetch", fetches, f + 1);
		apb(1, 12'h000, 32'h10);
		cmd(0, 1, 0);
		wm(hm(16, 1), "wdrst");
		chk("wd rst", watchdog_reset, 1);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		wm(1, "rerun");
		wrap_up();
	end
endmodule // power_saving_mode_controller_bench
`default_nettype wire

// ==== verilog/clk_div.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "psm_map.svh"
module clk_div (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	clk_div_if.div    dif
);
	logic [5:0] cnt;
	logic [5:0] ratio_hold;
	wire        wrap = (cnt == ratio_hold - 6'h01);

	// New ratio is loaded only at wrap so no short pulse escapes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt        <= 6'h00;
			ratio_hold <= `PSM_DIV_RUN;
		end else if (!dif.run) begin
			cnt <= 6'h00;
		end else if (wrap) begin
			cnt        <= 6'h00;
			ratio_hold <= dif.ratio;
		end else begin
			cnt <= cnt + 6'h01;
		end
	end

	assign dif.tick = dif.run && wrap;

	property p_run_wrap;
		@(posedge pclk) disable iff (!presetn) dif.tick |=> (cnt == 6'h00);
	endproperty
	a_run_wrap: assert property (p_run_wrap) else $error("divider did not restart");
endmodule // clk_div
`default_nettype wire

// ==== verilog/clk_div_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface clk_div_if;
	logic [5:0] ratio;
	logic       run;
	logic       tick;
	modport ctrl (output ratio, output run, input tick);
	modport div (input ratio, input run, output tick);
endinterface
`default_nettype wire

// ==== verilog/power_saving_mode_controller.sv ====
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "psm_map.svh"
module power_saving_mode_controller #(
	parameter int STARTUP_CYC = `PSM_STARTUP_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// CPU core
	input  wire logic        wfi_instr,
	input  wire logic        halt_instr,
	input  wire logic        watchdog_active,
	input  wire logic [1:0]  isr_priority,
	output var  logic        cpu_clk_en,
	output var  logic        prio_force,
	output var  logic [1:0]  prio_value,
	output var  logic        cc_push,
	output var  logic        fetch_vector,
	output var  logic        watchdog_reset,
	// Interrupt sources (pins)
	input  wire logic        irq_any,
	input  wire logic        irq_halt_wake,
	input  wire logic        irq_time_base,
	// Clock gating
	output var  logic        periph_clk_en,
	output var  logic        time_base_clk_en,
	output var  logic        osc_enable
);
	clk_div_if dif();

	psm_pkg::mode_t mode;
	psm_pkg::mode_t next_mode;
	logic       slow_mode_select;
	logic [1:0] slow_clock_divider_select;
	logic       oscillator_interrupt_enable;
	logic       watchdog_halt_option;
	logic [12:0] startup_cnt;
	logic       wake_by_irq;
	logic [2:0] sync_a;
	logic [2:0] sync_b;

	// Synchronise the interrupt pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {irq_time_base, irq_halt_wake, irq_any};
			sync_b <= sync_a;
		end
	end
	wire irq_s  = sync_b[0];
	wire hwak_s = sync_b[1];
	wire tb_s   = sync_b[2];

	// APB decode
	wire acc       = psel && penable;
	wire hit_ctrl  = (paddr == `PSM_ADDR_CTRL);
	wire hit_stat  = (paddr == `PSM_ADDR_STATUS);
	wire wr_ctrl   = acc && pwrite && hit_ctrl;
	wire unmapped  = !(hit_ctrl || hit_stat);

	function automatic logic [5:0] div_ratio(input logic slow, input logic [1:0] sel);
		if (!slow)
			div_ratio = `PSM_DIV_RUN;
		else case (sel)
			2'h0:    div_ratio = `PSM_DIV_SEL0;
			2'h1:    div_ratio = `PSM_DIV_SEL1;
			2'h2:    div_ratio = `PSM_DIV_SEL2;
			default: div_ratio = `PSM_DIV_SEL3;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_mode_select            <= 1'b0;
			slow_clock_divider_select   <= 2'h0;
			oscillator_interrupt_enable <= 1'b0;
			watchdog_halt_option        <= 1'b0;
		end else if (wr_ctrl) begin
			slow_mode_select            <= pwdata[`PSM_CTRL_SLOW];
			slow_clock_divider_select   <= pwdata[`PSM_CTRL_SEL_HI:`PSM_CTRL_SEL_LO];
			oscillator_interrupt_enable <= pwdata[`PSM_CTRL_OIE];
			watchdog_halt_option        <= pwdata[`PSM_CTRL_WATCHDOG_HALT_OPTION];
		end
	end

	wire [31:0] ctrl_rd = {27'h0, watchdog_halt_option, oscillator_interrupt_enable,
		slow_clock_divider_select, slow_mode_select};
	wire [31:0] stat_rd = {26'h0, mode};
	wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : 32'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !pready;
			pslverr <= psel && !pready && unmapped;
			prdata  <= (psel && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// Divider: stopped in halt only, where the oscillator is off; it keeps running in active-halt and in wait
	assign dif.ratio = div_ratio(slow_mode_select, slow_clock_divider_select);
	assign dif.run   = (mode != psm_pkg::ST_HALT);
	clk_div u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.dif     (dif)
	);

	// Wake conditions
	wire ahalt_wake  = irq_s && (hwak_s || tb_s);
	wire halt_wake   = irq_s && hwak_s && !tb_s;
	wire start_done  = (startup_cnt == 13'(STARTUP_CYC - 1));
	// Halt with watchdog running: option decides reset; OSCILLATOR_INTERRUPT_ENABLE set never resets
	wire halt_to_rst = watchdog_active && watchdog_halt_option && !oscillator_interrupt_enable;

	always_comb begin
		next_mode = mode;
		case (mode)
			psm_pkg::ST_RUN: begin
				if (halt_instr) begin
					if (oscillator_interrupt_enable)
						next_mode = psm_pkg::ST_AHALT;
					else if (halt_to_rst)
						next_mode = psm_pkg::ST_WDRST;
					else
						next_mode = psm_pkg::ST_HALT;
				end else if (wfi_instr) begin
					next_mode = psm_pkg::ST_WAIT;
				end
			end
			psm_pkg::ST_WAIT:
				if (irq_s)
					next_mode = psm_pkg::ST_RUN;
			psm_pkg::ST_AHALT:
				if (ahalt_wake)
					next_mode = psm_pkg::ST_START;
			psm_pkg::ST_HALT:
				if (halt_wake)
					next_mode = psm_pkg::ST_START;
			psm_pkg::ST_START:
				if (start_done)
					next_mode = psm_pkg::ST_RUN;
			psm_pkg::ST_WDRST:
				next_mode = psm_pkg::ST_WDRST;
			default:
				next_mode = psm_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode        <= psm_pkg::ST_RUN;
			startup_cnt <= 13'h0;
			wake_by_irq <= 1'b0;
		end else begin
			mode        <= next_mode;
			startup_cnt <= (mode == psm_pkg::ST_START) ? startup_cnt + 13'h1 : 13'h0;
			if (mode != psm_pkg::ST_START)
				wake_by_irq <= irq_s;
		end
	end

	// Outputs, all registered
	wire leaving = (mode == psm_pkg::ST_WAIT && next_mode == psm_pkg::ST_RUN)
		|| (mode == psm_pkg::ST_START && next_mode == psm_pkg::ST_RUN);
	wire entering = (mode == psm_pkg::ST_RUN)
		&& (next_mode == psm_pkg::ST_WAIT || next_mode == psm_pkg::ST_AHALT
		|| next_mode == psm_pkg::ST_HALT);
	// Start-up uses the request seen at wake time, the pin may have dropped since
	wire wake_irq = (mode == psm_pkg::ST_START) ? wake_by_irq : irq_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_en       <= 1'b0;
			periph_clk_en    <= 1'b0;
			time_base_clk_en <= 1'b0;
			osc_enable       <= 1'b1;
			prio_force       <= 1'b0;
			prio_value       <= `PSM_PRIO_ENABLE;
			cc_push          <= 1'b0;
			fetch_vector     <= 1'b0;
			watchdog_reset   <= 1'b0;
		end else begin
			cpu_clk_en       <= dif.tick && (next_mode == psm_pkg::ST_RUN);
			periph_clk_en    <= dif.tick && (next_mode == psm_pkg::ST_RUN
				|| next_mode == psm_pkg::ST_WAIT);
			time_base_clk_en <= dif.tick && (next_mode != psm_pkg::ST_HALT);
			osc_enable       <= (next_mode != psm_pkg::ST_HALT);
			prio_force       <= entering || (leaving && wake_irq);
			// Level holds between events, as the core's current priority does
			prio_value       <= entering ? `PSM_PRIO_ENABLE
				: ((leaving && wake_irq) ? isr_priority : prio_value);
			cc_push          <= leaving && wake_irq;
			fetch_vector     <= leaving;
			watchdog_reset   <= (next_mode == psm_pkg::ST_WDRST);
		end
	end

	// Checks
	property p_reset_run;
		@(posedge pclk) disable iff (!presetn) $rose(presetn) |-> mode == psm_pkg::ST_RUN;
	endproperty
	a_reset_run: assert property (p_reset_run) else $error("not in run after reset");
	property p_halt_select;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_RUN && halt_instr && oscillator_interrupt_enable)
		|=> mode == psm_pkg::ST_AHALT;
	endproperty
	a_halt_select: assert property (p_halt_select) else $error("active-halt not chosen");
	property p_wait_entry;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_RUN && wfi_instr && !halt_instr) |=> ##0 (prio_force
		&& prio_value == `PSM_PRIO_ENABLE && mode == psm_pkg::ST_WAIT);
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");
	property p_wait_cpu_off;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_WAIT && $past(mode) == psm_pkg::ST_WAIT) |-> !cpu_clk_en;
	endproperty
	a_wait_cpu_off: assert property (p_wait_cpu_off) else $error("cpu clocked in wait");
	property p_halt_osc;
		@(posedge pclk) disable iff (!presetn)
		mode == psm_pkg::ST_HALT |-> !osc_enable && !periph_clk_en;
	endproperty
	a_halt_osc: assert property (p_halt_osc) else $error("oscillator on in halt");
	property p_tb_no_halt_wake;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_HALT && tb_s) |=> mode == psm_pkg::ST_HALT;
	endproperty
	a_tb_no_halt_wake: assert property (p_tb_no_halt_wake) else $error("time base left halt");
	property p_startup_len;
		@(posedge pclk) disable iff (!presetn)
		$rose(mode == psm_pkg::ST_START) |-> startup_cnt == 13'h0;
	endproperty
	a_startup_len: assert property (p_startup_len) else $error("startup count not zero");
	property p_startup_end;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_START && start_done) |=> mode == psm_pkg::ST_RUN && fetch_vector;
	endproperty
	a_startup_end: assert property (p_startup_end) else $error("startup did not end");
	property p_ahalt_no_wdrst;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_RUN && halt_instr && oscillator_interrupt_enable)
		|=> !watchdog_reset;
	endproperty
	a_ahalt_no_wdrst: assert property (p_ahalt_no_wdrst) else $error("watchdog reset");
	property p_wait_wake;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_WAIT && irq_s) |=> mode == psm_pkg::ST_RUN && fetch_vector;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("wait did not wake");

	property p_wake_push;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_WAIT && irq_s)
		|=> cc_push && prio_force && prio_value == $past(isr_priority);
	endproperty
	a_wake_push: assert property (p_wake_push) else $error("priority not reloaded");

	property p_wait_periph;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_WAIT && next_mode == psm_pkg::ST_WAIT && dif.tick)
		|=> periph_clk_en && !cpu_clk_en;
	endproperty
	a_wait_periph: assert property (p_wait_periph) else $error("peripherals stopped");

	property p_ahalt_entry;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_RUN && halt_instr && oscillator_interrupt_enable)
		|=> prio_force && prio_value == `PSM_PRIO_ENABLE;
	endproperty
	a_ahalt_entry: assert property (p_ahalt_entry) else $error("priority not forced");

	property p_ahalt_pending;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_AHALT && irq_s && hwak_s) |=> mode == psm_pkg::ST_START;
	endproperty
	a_ahalt_pending: assert property (p_ahalt_pending) else $error("pending did not wake");

	property p_ahalt_tb_wake;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_AHALT && irq_s && tb_s) |=> mode == psm_pkg::ST_START;
	endproperty
	a_ahalt_tb_wake: assert property (p_ahalt_tb_wake) else $error("time base no wake");

	property p_ahalt_clocks;
		@(posedge pclk) disable iff (!presetn)
		mode == psm_pkg::ST_AHALT |-> !cpu_clk_en && !periph_clk_en && osc_enable;
	endproperty
	a_ahalt_clocks: assert property (p_ahalt_clocks) else $error("active-halt clocks wrong");

	property p_halt_entry;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_RUN && halt_instr && !oscillator_interrupt_enable
		&& !(watchdog_active && watchdog_halt_option))
		|=> mode == psm_pkg::ST_HALT && prio_force && prio_value == `PSM_PRIO_ENABLE;
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");

	property p_halt_clocks;
		@(posedge pclk) disable iff (!presetn)
		mode == psm_pkg::ST_HALT |-> !cpu_clk_en && !time_base_clk_en;
	endproperty
	a_halt_clocks: assert property (p_halt_clocks) else $error("clock running in halt");

	property p_osc_restart;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_HALT && irq_s && hwak_s && !tb_s)
		|=> osc_enable && mode == psm_pkg::ST_START;
	endproperty
	a_osc_restart: assert property (p_osc_restart) else $error("oscillator not restarted");

	property p_wdrst_entry;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_RUN && halt_instr && !oscillator_interrupt_enable
		&& watchdog_active && watchdog_halt_option) |=> watchdog_reset;
	endproperty
	a_wdrst_entry: assert property (p_wdrst_entry) else $error("watchdog reset missing");

	property p_wdrst_option_off;
		@(posedge pclk) disable iff (!presetn)
		(mode == psm_pkg::ST_RUN && halt_instr && !watchdog_halt_option) |=> !watchdog_reset;
	endproperty
	a_wdrst_option_off: assert property (p_wdrst_option_off) else $error("unwanted reset");

	c_wait: cover property (@(posedge pclk) mode == psm_pkg::ST_WAIT ##1 mode == psm_pkg::ST_RUN);
	c_ahalt: cover property (@(posedge pclk) mode == psm_pkg::ST_AHALT ##1 mode == psm_pkg::ST_START);
	c_halt: cover property (@(posedge pclk) mode == psm_pkg::ST_HALT ##1 mode == psm_pkg::ST_START);
	c_slow_wait: cover property (@(posedge pclk)
		mode == psm_pkg::ST_WAIT && slow_mode_select && periph_clk_en);
	c_wdrst: cover property (@(posedge pclk)
		mode == psm_pkg::ST_RUN ##1 mode == psm_pkg::ST_WDRST);
endmodule // power_saving_mode_controller
`default_nettype wire

// ==== verilog/psm_map.svh ====
// What this block does
// - Reset enters run mode, clock divided by two
// - Slow enable bit plus two-bit divider select
// - Slow mode divides by 4, 8, 16, 32
// - Wait during slow mode keeps slow clock
// - Wait stops CPU clock, peripherals keep running
// - Wait entry forces priority bits to 10
// - Wait ends on interrupt or reset
// - Wake interrupt pushes and reloads priority bits
// - Halt picks active-halt when oscillator enable set
// - Active-halt exits with 4096-cycle delay
// - Active-halt entry forces 10, pending wakes
// - Active-halt clocks only oscillator and time base
// - Active-halt with enable set avoids watchdog reset
// - Halt exits by wake interrupt, 4096 delay
// - Halt entry clears mask, pending wakes
// - Halt stops oscillator and peripheral clocks
// - Watchdog halt option may reset instead
// - Time-base interrupt wakes active-halt only
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH
`define PSM_ADDR_CTRL     12'h000
`define PSM_ADDR_STATUS   12'h004
`define PSM_DIV_RUN       6'h02
`define PSM_DIV_SEL0      6'h04
`define PSM_DIV_SEL1      6'h08
`define PSM_DIV_SEL2      6'h10
`define PSM_DIV_SEL3      6'h20
`define PSM_STARTUP_CYC   4096
`define PSM_PRIO_ENABLE   2'h2
`define PSM_CTRL_SLOW     0
`define PSM_CTRL_SEL_LO   1
`define PSM_CTRL_SEL_HI   2
`define PSM_CTRL_OIE      3
`define PSM_CTRL_WATCHDOG_HALT_OPTION  4
`endif

// ==== verilog/psm_pkg.sv ====
package psm_pkg;
	typedef enum logic [5:0] {
		ST_RUN   = 6'h01,
		ST_WAIT  = 6'h02,
		ST_AHALT = 6'h04,
		ST_HALT  = 6'h08,
		ST_START = 6'h10,
		ST_WDRST = 6'h20
	} mode_t;
endpackage
